// ---- src/adcclk_ctrl.v ----
// adc clock select, modulator divider, decimation timing and reference buffer control
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "adcclk_defs.vh"

module adcclk_ctrl #(
  parameter OSR_W = 17
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        osc_clk_tick,
  input  wire        ext_clk_tick,
  input  wire        start_conv,
  output wire        sys_clk_tick,
  output wire        mod_clk_tick,
  output reg         data_ready,
  output reg         converting,
  output wire        pos_refbuf_disable,
  output wire        neg_refbuf_disable,
  output wire [1:0]  ref_source_select,
  output wire        internal_ref_routed
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_CONV  = 2'd2;

  reg  [4:0]       rate_r;
  reg  [3:0]       ref_r;
  reg  [1:0]       state_r;
  reg  [1:0]       state_nxt;
  reg  [3:0]       dly_cnt_r;
  reg  [3:0]       dly_cnt_nxt;
  reg              wr_pend_r;
  reg  [7:0]       wr_addr_r;
  reg  [31:0]      rd_data_nxt;
  reg  [OSR_W-1:0] osr;
  reg              cfg_restart;
  reg              restart_nxt;
  wire [3:0]       rate_code;
  wire             clk_sel_ext;
  wire             addr_ok;
  wire             dec_tick;
  wire             soft_reset;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];

  // write data arrives one cycle after the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  assign soft_reset = wr_pend_r && (wr_addr_r == `ADCCLK_OFF_CMD) && (hwdata == `ADCCLK_CMD_RESET);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_r <= `ADCCLK_RATE_RST;
      ref_r  <= `ADCCLK_REF_RST;
    end else if (soft_reset) begin
      rate_r <= `ADCCLK_RATE_RST;
      ref_r  <= `ADCCLK_REF_RST;
    end else if (wr_pend_r && wr_addr_r == `ADCCLK_OFF_RATE) begin
      rate_r <= hwdata[4:0];
    end else if (wr_pend_r && wr_addr_r == `ADCCLK_OFF_REF) begin
      ref_r <= hwdata[3:0];
    end
  end

  // restart both dividers on any rate/clock write so no odd-length period escapes
  always @* begin
    restart_nxt = soft_reset || (wr_pend_r && wr_addr_r == `ADCCLK_OFF_RATE);
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cfg_restart <= 1'b0;
    else cfg_restart <= restart_nxt;
  end

  assign rate_code          = rate_r[`ADCCLK_RATE_CODE_LSB +: 4];
  assign clk_sel_ext        = rate_r[`ADCCLK_RATE_CLK_BIT];
  assign pos_refbuf_disable = ref_r[`ADCCLK_REF_PBUF_BIT];
  assign neg_refbuf_disable = ref_r[`ADCCLK_REF_NBUF_BIT];
  assign ref_source_select  = ref_r[`ADCCLK_REF_SEL_LSB +: 2];
  assign internal_ref_routed = (ref_source_select == `ADCCLK_REF_INTERNAL);

  // all timing counts in ticks of the chosen source, so rates track its real frequency
  assign sys_clk_tick = clk_sel_ext ? ext_clk_tick : osc_clk_tick;

  adcclk_tick_div #(.W(5)) u_mod_div (
    .clk     (hclk),
    .rst_n   (hresetn),
    .en      (sys_clk_tick),
    .restart (cfg_restart),
    .ratio   (5'd16),
    .tick    (mod_clk_tick)
  );

  // reserved codes fall back to the slowest ratio rather than an undefined one
  always @* begin
    case (rate_code)
      4'h0: osr = 17'd102400;
      4'h1: osr = 17'd51200;
      4'h2: osr = 17'd25600;
      4'h3: osr = 17'd15360;
      4'h4: osr = 17'd12800;
      4'h5: osr = 17'd5120;
      4'h6: osr = 17'd4264;
      4'h7: osr = 17'd2560;
      4'h8: osr = 17'd1280;
      4'h9: osr = 17'd640;
      4'ha: osr = 17'd320;
      4'hb: osr = 17'd256;
      4'hc: osr = 17'd128;
      4'hd: osr = 17'd64;
      default: osr = 17'd102400;
    endcase
  end

  // decimator counts only while sampling; held restarted outside the conversion state
  adcclk_tick_div #(.W(OSR_W)) u_dec_div (
    .clk     (hclk),
    .rst_n   (hresetn),
    .en      (mod_clk_tick && state_r == ST_CONV),
    .restart (cfg_restart || state_r != ST_CONV),
    .ratio   (osr),
    .tick    (dec_tick)
  );

  always @* begin
    state_nxt   = state_r;
    dly_cnt_nxt = dly_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (start_conv) begin
          state_nxt   = ST_DELAY;
          dly_cnt_nxt = 4'd0;
        end
      end
      ST_DELAY: begin
        if (mod_clk_tick) begin
          if (dly_cnt_r == 4'd13) state_nxt = ST_CONV;
          dly_cnt_nxt = dly_cnt_r + 4'd1;
        end
      end
      ST_CONV: begin
        state_nxt = ST_CONV;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (cfg_restart && state_r != ST_IDLE) begin
      state_nxt   = ST_DELAY;
      dly_cnt_nxt = 4'd0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= ST_IDLE;
      dly_cnt_r  <= 4'd0;
      data_ready <= 1'b0;
      converting <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      dly_cnt_r  <= dly_cnt_nxt;
      data_ready <= dec_tick;
      converting <= (state_nxt != ST_IDLE);
    end
  end

  always @* begin
    rd_data_nxt = 32'h00000000;
    case (haddr[7:0])
      `ADCCLK_OFF_RATE:   rd_data_nxt = {27'h0, rate_r};
      `ADCCLK_OFF_REF:    rd_data_nxt = {28'h0, ref_r};
      `ADCCLK_OFF_STATUS: rd_data_nxt = {29'h0, internal_ref_routed, state_r};
      default:            rd_data_nxt = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (addr_ok && !hwrite) hrdata <= rd_data_nxt;
  end
endmodule // adcclk_ctrl

// ---- src/adcclk_defs.vh ----
// constants for the adc clock and decimation control block
`ifndef ADCCLK_DEFS_VH
`define ADCCLK_DEFS_VH
`define ADCCLK_OFF_RATE      8'h04
`define ADCCLK_OFF_REF       8'h05
`define ADCCLK_OFF_STATUS    8'h08
`define ADCCLK_OFF_CMD       8'h0c
`define ADCCLK_RATE_CODE_LSB 0
`define ADCCLK_RATE_CLK_BIT  4
`define ADCCLK_REF_SEL_LSB   0
`define ADCCLK_REF_NBUF_BIT  2
`define ADCCLK_REF_PBUF_BIT  3
`define ADCCLK_RATE_RST      5'h00
`define ADCCLK_REF_RST       4'h0
`define ADCCLK_REF_INTERNAL  2'h2
`define ADCCLK_MOD_DIV       16
`define ADCCLK_CFG_DELAY_MOD 14
`define ADCCLK_CMD_RESET     32'h00000006
`endif

// ---- src/adcclk_tick_div.v ----
// tick divider with synchronous restart, used for clock division and decimation
`timescale 1ns/1ps
module adcclk_tick_div #(
  parameter W = 17
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         en,
  input  wire         restart,
  input  wire [W-1:0] ratio,
  output reg          tick
);
  reg [W-1:0] cnt_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (en) begin
      if (cnt_r == ratio - {{(W-1){1'b0}}, 1'b1}) begin
        cnt_r <= {W{1'b0}};
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // adcclk_tick_div

// ---- test/adcclk_ctrl_props.sv ----
// assertion checker for the adc clock and decimation control block
`timescale 1ns/1ps
module adcclk_ctrl_props (
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire       hready,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       osc_clk_tick,
  input wire       ext_clk_tick,
  input wire       sys_clk_tick,
  input wire       mod_clk_tick,
  input wire       data_ready,
  input wire       converting,
  input wire       pos_refbuf_disable,
  input wire       neg_refbuf_disable,
  input wire [1:0] ref_source_select,
  input wire       internal_ref_routed
);
  reg [5:0]  sc_r;
  reg [16:0] mc_r;
  reg        wph_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // 17 bits hold the largest ratio plus delay, so no wrap
  // 6 bits for sc_r: a divider restart can stretch one gap to about 32 ticks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc_r <= 6'h00;
      mc_r <= 17'h00000;
      wph_r <= 1'b0;
    end else begin
      sc_r <= mod_clk_tick ? 6'h00 : sc_r + {5'h00, sys_clk_tick};
      mc_r <= (data_ready || !converting) ? 17'h0 : mc_r + {16'h0, mod_clk_tick};
      wph_r <= hsel & hready & htrans[1] & hwrite;
    end
  end
  AST_RST_STATE: assert property ($rose(hresetn) |-> sys_clk_tick == osc_clk_tick
    && !pos_refbuf_disable && !neg_refbuf_disable) else $error("state after reset");
  AST_SYS_SRC: assert property (sys_clk_tick |-> osc_clk_tick || ext_clk_tick)
    else $error("system tick without source tick");
  AST_MOD_GAP: assert property (mod_clk_tick |-> sc_r >= 6'd15) else $error("short modulator period");
  AST_DR_PULSE: assert property (data_ready |=> !data_ready [*8]) else $error("data ready too long");
  AST_DR_GAP: assert property (data_ready |-> mc_r >= 17'd63) else $error("short output period");
  AST_DR_CONV: assert property (data_ready |-> converting) else $error("result while idle");
  AST_REF_ROUTE: assert property (internal_ref_routed == (ref_source_select == 2'h2))
    else $error("internal reference routing");
  AST_BUF_WRITE: assert property (($changed(pos_refbuf_disable) || $changed(neg_refbuf_disable))
    |-> $past(wph_r)) else $error("buffer bit moved without write");
  cover property (data_ready);
  cover property ($rose(converting));
  cover property (wph_r);
endmodule // adcclk_ctrl_props

bind adcclk_ctrl adcclk_ctrl_props adcclk_ctrl_props_i (.*);

// ---- test/adcclk_ctrl_bench.sv ----
// self-checking bench for the adc clock and decimation control block
`timescale 1ns/1ps
module adcclk_ctrl_bench;
  reg          hclk;
  reg          hresetn = 1'b0;
  reg          hsel = 1'b0;
  reg  [31:0]  haddr = 32'h0;
  reg  [1:0]   htrans = 2'h0;
  reg          hwrite = 1'b0;
  reg  [31:0]  hwdata = 32'h0;
  reg          ext_clk_tick = 1'b0;
  reg          start_conv = 1'b0;
  wire [31:0]  hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         sys_clk_tick;
  wire         mod_clk_tick;
  wire         data_ready;
  wire         converting;
  wire         pos_refbuf_disable;
  wire         neg_refbuf_disable;
  wire [1:0]   ref_source_select;
  wire         internal_ref_routed;
  logic [31:0] q;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;
  int          i;
  adcclk_ctrl adcclk_ctrl_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .osc_clk_tick(1'b1),
    .ext_clk_tick, .start_conv, .sys_clk_tick, .mod_clk_tick, .data_ready, .converting,
    .pos_refbuf_disable, .neg_refbuf_disable, .ref_source_select, .internal_ref_routed
  );
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // external source ticks every second cycle, half the oscillator rate
  always @(posedge hclk) ext_clk_tick <= ~ext_clk_tick;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      finish_test;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task ahb(input bit w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task gap(input bit s, output int c);
    c = 0;
    do @(posedge hclk); while ((s ? data_ready : mod_clk_tick) !== 1'b1);
    do begin
      @(posedge hclk);
      c++;
    end while ((s ? data_ready : mod_clk_tick) !== 1'b1);
  endtask
  task finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, 8'h04, 0);
    chk("rate", q, 0);
    for (i = 0; i < 4; i++) begin
      ahb(1, 8'h05, {28'h0, i[1:0], i[1:0]});
      ahb(0, 8'h05, 0);
      chk("ref", q, {28'h0, i[1:0], i[1:0]});
      chk("pins", {pos_refbuf_disable, neg_refbuf_disable, ref_source_select, internal_ref_routed},
          {i[1:0], i[1:0], i == 2});
      ahb(0, 8'h08, 0);
      chk("stat", q, {29'h0, i == 2, 2'h0});
    end
    ahb(1, 8'h05, 32'he);
    ahb(0, 8'h08, 0);
    chk("intref", {q[2], pos_refbuf_disable, neg_refbuf_disable}, 3'h7);
    ahb(1, 8'h10, 32'hffffffff);
    ahb(0, 8'h10, 0);
    chk("unmapped", q, 0);
    ahb(1, 8'h04, 32'h1d);
    gap(0, n);
    chk("ext_mod", n, 32);
    ahb(1, 8'h04, 32'h0d);
    gap(0, n);
    chk("osc_mod", n, 16);
    start_conv <= 1'b1;
    @(posedge hclk);
    start_conv <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (data_ready !== 1'b1);
    chk("first", n >= 1248, 1);
    gap(1, n);
    chk("osr13", n, 1024);
    @(posedge hclk);
    ahb(1, 8'h04, 32'h0c);
    gap(1, n);
    chk("osr12", n, 2048);
    @(posedge hclk);
    ahb(1, 8'h0c, 32'h6);
    ahb(0, 8'h04, 0);
    chk("soft", {q[4:0], pos_refbuf_disable, neg_refbuf_disable}, 0);
    finish_test;
  end
endmodule // adcclk_ctrl_bench
